// ### verilog/ufc_top.sv
// uart fifo control, interrupt identification/enable and baud generator behind an apb slave
`timescale 1ns/100ps
`include "ufc_regs.svh"

// What this block does
// - fcr bits 7:6 pick rx threshold 1/4/8/14
// - fcr bit3 sets dma mode 1 only with fifo
// - fcr bit2 pulses tx fifo reset, self-clears
// - fcr bit1 pulses rx fifo reset, self-clears
// - fcr bit0 enables fifo mode, set first
// - iir bits 7:6 show fifo mode, 5:4 zero
// - iir bit0 high only when nothing pending
// - rx data / threshold is second, code 0100
// - fifo timeout after four char times, 1100
// - tx empty 0010, cleared by write or iir read
// - handshake changes lowest priority, code 0000
// - iir bit3 zero outside fifo mode
// - ier bits 3:0 enable sources, 7:4 zero
// - divide pre-divided reference by 16-bit divisor
// - generator output is sixteen times bit rate
// - high speed mode uses undivided 24 MHz
// - pre-divider 13, 1.625 or 1.0 by config
// - irq output only when hcr bit3 set
// - line status error flags clear on read
module ufc_top #(
  parameter int THR_W = 5
) (
  input  wire logic              clock_in,
  input  wire logic              rst_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [7:0]        paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic                   pready_out,
  output logic                   pslverr_out,
  output logic [31:0]            prdata_out,
  input  wire ufc_pkg::ufc_core_t core_in,
  output logic                   irq_out,
  output logic                   baud16_out,
  output logic                   fifo_mode_out,
  output logic                   dma_mode_out,
  output logic                   tx_fifo_reset_out,
  output logic                   rx_fifo_reset_out
);

  // ---------------------------------------------------------------
  // constants
  // ---------------------------------------------------------------
  localparam logic [6:0] REF_STEP  = 7'(`UFC_REF_CLK_MHZ);
  localparam logic [6:0] REF_MOD   = 7'(`UFC_SYS_CLK_MHZ);
  localparam logic [4:0] PRE_MOD   = 5'(`UFC_PREDIV_DEN);
  localparam logic [9:0] TO_TICKS  = 10'(`UFC_TIMEOUT_CHARS * `UFC_CHAR_BITS * `UFC_OVERSAMPLE);

  ufc_pkg::ufc_state_t q, d;

  // receive threshold in bytes
  // the table is fixed; only the two select bits are stored
  function automatic logic [THR_W-1:0] thr_bytes(input logic [1:0] sel);
    unique case (sel)
      2'b00: thr_bytes = THR_W'(1);
      2'b01: thr_bytes = THR_W'(4);
      2'b10: thr_bytes = THR_W'(8);
      2'b11: thr_bytes = THR_W'(14);
    endcase
  endfunction

  // ---------------------------------------------------------------
  // interrupt sources and identification
  // ---------------------------------------------------------------
  logic       rda_raw_w, rls_w, rda_w, to_w, thre_w, ms_w, any_w;
  logic [7:0] iir_w;

  // enables mask each source before the priority chain, so a disabled source
  // never hides a lower enabled one; line and handshake flags are sticky
  always_comb begin
    // in fifo mode data-ready follows the level against threshold, else any byte held
    rda_raw_w = q.fifo_en ? (core_in.rx_level >= thr_bytes(q.rx_thr)) : (core_in.rx_level != 5'h00);
    rls_w     = (|q.ls_flags) & q.ier[2];
    rda_w     = rda_raw_w & q.ier[0];
    to_w      = q.to_flag & q.fifo_en & q.ier[0];  // stale flag hidden once fifo mode is off
    thre_w    = q.thre_flag & q.ier[1];
    ms_w      = (|q.hs_flags) & q.ier[3];
    any_w     = rls_w | rda_w | to_w | thre_w | ms_w;
    iir_w     = {q.fifo_en, q.fifo_en, 2'b00, `UFC_IID_NONE};
    if (rls_w) begin
      iir_w[3:0] = `UFC_IID_LINE;
    end else if (rda_w) begin
      iir_w[3:0] = `UFC_IID_RX_DATA;
    end else if (to_w) begin
      iir_w[3:0] = `UFC_IID_TIMEOUT;
    end else if (thre_w) begin
      iir_w[3:0] = `UFC_IID_TX_EMPTY;
    end else if (ms_w) begin
      iir_w[3:0] = `UFC_IID_HANDSHAKE;
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic        acc_w, done_w, wr_w, rd_w;
  logic [7:0]  wb_w;
  logic [7:0]  rsum_w;
  logic [4:0]  psum_w, pstep_w;
  logic        ref_tick_w, pre_tick_w;

  always_comb begin
    d          = q;
    d.tx_rst   = 1'b0;
    d.rx_rst   = 1'b0;
    d.baud16   = 1'b0;
    acc_w      = psel_in & penable_in;
    // a transfer completes at the edge where pready is seen high
    done_w     = acc_w & q.pready;
    wr_w       = done_w & pwrite_in & ~q.pslverr;
    rd_w       = done_w & ~pwrite_in & ~q.pslverr;
    wb_w       = pwdata_in[7:0];

    // apb: one wait state so read data comes from a flop
    // the cost is one extra cycle per access, the gain a flop-to-pin read path
    d.pready   = acc_w & ~q.pready;
    d.pslverr  = 1'b0;
    if (acc_w & ~q.pready) begin
      d.prdata = 32'h0000_0000;
      unique case (paddr_in)
        `UFC_OFF_FIFO_CONTROL: d.prdata = 32'h0000_0000;  // write only
        `UFC_OFF_INT_ID:       d.prdata[7:0] = iir_w;
        `UFC_OFF_INT_ENABLE:   d.prdata[7:0] = q.ier;
        `UFC_OFF_DIVISOR_LOW:  d.prdata[7:0] = q.div[7:0];
        `UFC_OFF_DIVISOR_HIGH: d.prdata[7:0] = q.div[15:8];
        `UFC_OFF_LINE_STATUS:  d.prdata[4:0] = {q.ls_flags, rda_raw_w};
        `UFC_OFF_HS_STATUS:    d.prdata[7:0] = {core_in.modem[3], core_in.modem[2], core_in.modem[1],
                                                core_in.modem[0], q.hs_flags};
        `UFC_OFF_CONFIG:       d.prdata[2:0] = {q.pre_sel, q.hs_sel};
        `UFC_OFF_HS_CONTROL:   d.prdata[`UFC_HCR_IRQ_EN] = q.irq_en;
        default:               d.pslverr = 1'b1;
      endcase
    end

    // register writes
    // writes to read-only offsets are dropped without an error
    if (wr_w) begin
      unique case (paddr_in)
        `UFC_OFF_FIFO_CONTROL: begin
          d.fifo_en  = wb_w[`UFC_FCR_FIFO_EN];
          d.dma_mode = wb_w[`UFC_FCR_DMA_MODE] & wb_w[`UFC_FCR_FIFO_EN];
          d.rx_thr   = wb_w[`UFC_FCR_THR_LSB +: 2];
          d.tx_rst   = wb_w[`UFC_FCR_TX_RESET];
          d.rx_rst   = wb_w[`UFC_FCR_RX_RESET];
        end
        `UFC_OFF_INT_ENABLE:   d.ier = wb_w & `UFC_IER_MASK;
        `UFC_OFF_DIVISOR_LOW:  d.div[7:0] = wb_w;
        `UFC_OFF_DIVISOR_HIGH: d.div[15:8] = wb_w;
        `UFC_OFF_CONFIG: begin
          d.hs_sel  = wb_w[0];
          d.pre_sel = ufc_pkg::ufc_prediv_t'(wb_w[2:1]);
        end
        `UFC_OFF_HS_CONTROL:   d.irq_en = wb_w[`UFC_HCR_IRQ_EN];
        default: ;
      endcase
    end

    // line error flags: only bits already reported by the read are cleared, new events win
    if (rd_w && paddr_in == `UFC_OFF_LINE_STATUS) begin
      d.ls_flags = q.ls_flags & ~q.prdata[4:1];
    end
    d.ls_flags = d.ls_flags | core_in.line_err;

    // handshake change flags, same reported-bits clearing
    if (rd_w && paddr_in == `UFC_OFF_HS_STATUS) begin
      d.hs_flags = q.hs_flags & ~q.prdata[3:0];
    end
    d.modem_prev = core_in.modem;
    d.hs_flags   = d.hs_flags | {core_in.modem[3] ^ q.modem_prev[3],
                                 ~core_in.modem[2] & q.modem_prev[2],   // ring trailing edge
                                 core_in.modem[1] ^ q.modem_prev[1],
                                 core_in.modem[0] ^ q.modem_prev[0]};

    // tx empty: sticky from the empty edge, cleared by a buffer write or by reading it as reported
    d.tx_empty_prev = core_in.tx_empty;
    if (core_in.tbr_write || (rd_w && paddr_in == `UFC_OFF_INT_ID && q.prdata[3:0] == `UFC_IID_TX_EMPTY)) begin
      d.thre_flag = 1'b0;
    end
    if (core_in.tx_empty & ~q.tx_empty_prev) begin
      d.thre_flag = 1'b1;
    end

    // receive timeout: count 16x ticks while data sits untouched in the fifo
    // the count stops at four characters so a long wait cannot wrap and fire again
    if (!q.fifo_en || core_in.rx_level == 5'h00 || core_in.rx_push || core_in.rbr_read) begin
      d.to_cnt = 10'h000;
    end else if (q.baud16 && q.to_cnt != TO_TICKS) begin
      d.to_cnt = q.to_cnt + 10'h001;
    end
    if (!q.fifo_en || core_in.rbr_read) begin
      d.to_flag = 1'b0;
    end else if (q.baud16 && q.to_cnt == TO_TICKS - 10'h001 && !core_in.rx_push) begin
      d.to_flag = 1'b1;
    end

    // 24 MHz reference ticks made from the system clock by phase accumulation
    // no 24 MHz clock exists here: the accumulator gives the same average rate,
    // with up to one system clock of jitter on each tick
    rsum_w     = {1'b0, q.ref_acc} + {1'b0, REF_STEP};
    ref_tick_w = rsum_w >= {1'b0, REF_MOD};
    d.ref_acc  = ref_tick_w ? 7'(rsum_w - {1'b0, REF_MOD}) : rsum_w[6:0];

    // pre-divider as a fraction of 13: steps 1, 8 or 13 give /13, /1.625, /1
    if (q.hs_sel) begin
      pstep_w = 5'(`UFC_STEP_DIV1);
    end else begin
      unique case (q.pre_sel)
        ufc_pkg::UFC_PRE_DIV1625: pstep_w = 5'(`UFC_STEP_DIV1625);
        ufc_pkg::UFC_PRE_DIV1:    pstep_w = 5'(`UFC_STEP_DIV1);
        default:                  pstep_w = 5'(`UFC_STEP_DIV13);
      endcase
    end
    psum_w     = {1'b0, q.pre_acc} + pstep_w;
    pre_tick_w = ref_tick_w & (psum_w >= PRE_MOD);
    if (ref_tick_w) begin
      d.pre_acc = (psum_w >= PRE_MOD) ? 4'(psum_w - PRE_MOD) : psum_w[3:0];
    end

    // divisor counter: the new divisor is loaded only at the end of a period, so no runt pulse
    // limitation: a large old divisor delays a new small one by up to one old period
    if (q.div_act == 16'h0000) begin
      d.div_act  = q.div;                                                   // idle until programmed
      d.baud_cnt = 16'h0000;
    end else if (pre_tick_w) begin
      if (q.baud_cnt >= q.div_act - 16'h0001) begin
        d.baud_cnt = 16'h0000;
        d.baud16   = 1'b1;
        d.div_act  = q.div;
      end else begin
        d.baud_cnt = q.baud_cnt + 16'h0001;
      end
    end

    // interrupt pin gated by the handshake control enable
    d.irq = any_w & q.irq_en;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state flops
  assign pready_out        = q.pready;
  assign pslverr_out       = q.pslverr;
  assign prdata_out        = q.prdata;
  assign irq_out           = q.irq;
  assign baud16_out        = q.baud16;
  assign fifo_mode_out     = q.fifo_en;
  assign dma_mode_out      = q.dma_mode;
  assign tx_fifo_reset_out = q.tx_rst;
  assign rx_fifo_reset_out = q.rx_rst;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  thresh_four_a: assert property (q.fifo_en && q.rx_thr == 2'b01 && core_in.rx_level == 5'd3
    |-> !rda_raw_w) else $error("rx threshold 4 met at 3 bytes");
  dma_gate_a: assert property (dma_mode_out |-> fifo_mode_out)
    else $error("dma mode 1 without fifo mode");
  tx_reset_pulse_a: assert property (tx_fifo_reset_out |=> !tx_fifo_reset_out)
    else $error("tx reset not self clearing");
  rx_reset_write_a: assert property (wr_w && paddr_in == `UFC_OFF_FIFO_CONTROL && pwdata_in[1]
    |=> rx_fifo_reset_out ##1 !rx_fifo_reset_out) else $error("rx reset pulse wrong");
  iir_top_bits_a: assert property (iir_w[5:4] == 2'b00 && iir_w[7:6] == {2{fifo_mode_out}})
    else $error("iir top bits wrong");
  iir_none_a: assert property (iir_w[0] == !any_w)
    else $error("iir pending bit wrong");
  line_first_a: assert property (rls_w |-> iir_w[3:0] == `UFC_IID_LINE)
    else $error("line status not top priority");
  bit3_fifo_a: assert property (!fifo_mode_out |-> !iir_w[3])
    else $error("iir bit3 set outside fifo mode");
  irq_follow_a: assert property (##1 irq_out == $past(any_w && q.irq_en))
    else $error("irq output does not follow enabled sources");
  baud_gap_a: assert property (baud16_out |=> !baud16_out [*3])
    else $error("baud pulses too close");
  lsr_clear_a: assert property (rd_w && paddr_in == `UFC_OFF_LINE_STATUS && core_in.line_err == 4'h0
    |=> q.ls_flags == ($past(q.ls_flags) & ~$past(q.prdata[4:1]))) else $error("line flags not cleared");

  // ---------------------------------------------------------------
  // priority, clearing and enables of the other sources
  // ---------------------------------------------------------------
  fifo_en_a: assert property (wr_w && paddr_in == `UFC_OFF_FIFO_CONTROL
    |=> fifo_mode_out == $past(pwdata_in[`UFC_FCR_FIFO_EN]))
    else $error("fifo enable not taken from the write");

  rda_second_a: assert property (rda_w && !rls_w
    |-> iir_w[3:0] == `UFC_IID_RX_DATA)
    else $error("data ready not second priority");
  rda_level_a: assert property (q.fifo_en && core_in.rx_level == 5'h00
    |-> !rda_raw_w)
    else $error("data ready with an empty fifo");

  timeout_code_a: assert property (to_w && !rls_w && !rda_w
    |-> iir_w[3:0] == `UFC_IID_TIMEOUT)
    else $error("timeout code wrong");
  timeout_clear_a: assert property (core_in.rbr_read
    |=> !q.to_flag)
    else $error("timeout not cleared by a buffer read");

  thre_code_a: assert property (thre_w && !rls_w && !rda_w && !to_w
    |-> iir_w[3:0] == `UFC_IID_TX_EMPTY)
    else $error("tx empty code wrong");
  thre_clear_a: assert property (core_in.tbr_write && !(core_in.tx_empty && !q.tx_empty_prev)
    |=> !q.thre_flag)
    else $error("tx empty not cleared by a buffer write");

  hs_code_a: assert property (ms_w && !rls_w && !rda_w && !to_w && !thre_w
    |-> iir_w[3:0] == `UFC_IID_HANDSHAKE)
    else $error("handshake code wrong");
  ier_upper_a: assert property (q.ier[7:4] == 4'h0)
    else $error("enable bits 7:4 not zero");

  // ---------------------------------------------------------------
  // baud generator
  // ---------------------------------------------------------------
  // silent until a divisor is loaded, then the divisor changes only at period ends
  baud_idle_a: assert property (q.div_act == 16'h0000
    |=> !baud16_out)
    else $error("baud pulse with no divisor");
  div_hold_a: assert property (q.div_act != 16'h0000 && !d.baud16
    |=> $stable(q.div_act))
    else $error("divisor changed inside a period");

  fast_ref_a: assert property (q.hs_sel && ref_tick_w
    |-> pre_tick_w)
    else $error("high speed mode divides the reference");
  slow_ref_a: assert property (!q.hs_sel && q.pre_sel == ufc_pkg::UFC_PRE_DIV13 && pre_tick_w
    |-> q.pre_acc == 4'hC)
    else $error("divide by 13 ticks early");

  // ---------------------------------------------------------------
  // interrupt pin and bus handshake
  // ---------------------------------------------------------------
  irq_gate_a: assert property (!q.irq_en
    |=> !irq_out)
    else $error("irq driven while its enable is clear");

  // pready is a single-cycle pulse; an error never comes without it
  ready_pulse_a: assert property (pready_out
    |=> !pready_out)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr_out
    |-> pready_out)
    else $error("pslverr without pready");

  // main scenarios reached
  timeout_seen_c: cover property (to_w && iir_w[3:0] == `UFC_IID_TIMEOUT);
  baud_tick_c:    cover property (baud16_out);
  thre_iir_c:     cover property (q.thre_flag ##1 !q.thre_flag);
  apb_err_c:      cover property (pready_out && pslverr_out);
  line_read_c:    cover property (rd_w && paddr_in == `UFC_OFF_LINE_STATUS);

endmodule

// ### inc/ufc_regs.svh
// register offsets, field positions, reset values and timing counts of the uart fifo/irq/baud block
`ifndef UFC_REGS_SVH
`define UFC_REGS_SVH
// register byte addresses
`define UFC_OFF_FIFO_CONTROL   8'h00
`define UFC_OFF_INT_ID         8'h04
`define UFC_OFF_INT_ENABLE     8'h08
`define UFC_OFF_DIVISOR_LOW    8'h0C
`define UFC_OFF_DIVISOR_HIGH   8'h10
`define UFC_OFF_LINE_STATUS    8'h14
`define UFC_OFF_HS_STATUS      8'h18
`define UFC_OFF_CONFIG         8'h1C
`define UFC_OFF_HS_CONTROL     8'h20
// fifo_control fields
`define UFC_FCR_FIFO_EN        0
`define UFC_FCR_RX_RESET       1
`define UFC_FCR_TX_RESET       2
`define UFC_FCR_DMA_MODE       3
`define UFC_FCR_THR_LSB        6
// interrupt identification codes, bits 3..0
`define UFC_IID_NONE           4'h1
`define UFC_IID_LINE           4'h6
`define UFC_IID_RX_DATA        4'h4
`define UFC_IID_TIMEOUT        4'hC
`define UFC_IID_TX_EMPTY       4'h2
`define UFC_IID_HANDSHAKE      4'h0
// interrupt_enable bits and handshake_control irq output enable bit
`define UFC_IER_MASK           8'h0F
`define UFC_HCR_IRQ_EN         3
// reset values
`define UFC_RST_DIVISOR        16'h0000
// timing: system clock, reference, pre-divider denominator and steps, character time
`define UFC_SYS_CLK_MHZ        100
`define UFC_REF_CLK_MHZ        24
`define UFC_PREDIV_DEN         13
`define UFC_STEP_DIV13         1
`define UFC_STEP_DIV1625       8
`define UFC_STEP_DIV1          13
`define UFC_OVERSAMPLE         16
`define UFC_CHAR_BITS          10
`define UFC_TIMEOUT_CHARS      4
`endif

// ### inc/ufc_pkg.sv
// types shared by the uart fifo/irq/baud block
package ufc_pkg;
  // what the rest of the uart reports to this block each cycle
  typedef struct packed {
    logic [4:0] rx_level;     // bytes held in the receive fifo (0/1 in non-fifo mode)
    logic       rx_push;      // a byte entered the receive fifo
    logic       rbr_read;     // software read the receive buffer
    logic       tbr_write;    // software wrote the transmit buffer
    logic       tx_empty;     // transmit buffer / fifo empty level
    logic [3:0] line_err;     // pulses: 0 overrun, 1 parity, 2 missing stop, 3 break
    logic [3:0] modem;        // levels, active high: 0 cts, 1 dsr, 2 ri, 3 dcd
  } ufc_core_t;

  // reference pre-divider choice
  typedef enum logic [1:0] { UFC_PRE_DIV13, UFC_PRE_DIV1625, UFC_PRE_DIV1, UFC_PRE_RSVD } ufc_prediv_t;

  // whole state of the block
  typedef struct packed {
    logic        fifo_en;
    logic        dma_mode;
    logic [1:0]  rx_thr;
    logic [7:0]  ier;
    logic [15:0] div;
    logic [15:0] div_act;
    logic        hs_sel;
    ufc_prediv_t pre_sel;
    logic        irq_en;
    logic [3:0]  ls_flags;
    logic [3:0]  hs_flags;
    logic [3:0]  modem_prev;
    logic        tx_empty_prev;
    logic        thre_flag;
    logic        to_flag;
    logic [9:0]  to_cnt;
    logic [6:0]  ref_acc;
    logic [3:0]  pre_acc;
    logic [15:0] baud_cnt;
    logic        baud16;
    logic        tx_rst;
    logic        rx_rst;
    logic        irq;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ufc_state_t;
endpackage

// ### dv/ufc_core_model.sv
// behavioural model of the rest of the uart that feeds the block's core port
`timescale 1ns/100ps
module ufc_core_model (
  input  wire logic          clock_in,
  input  wire logic          rst_in,
  input  wire logic          push_in,
  input  wire logic          pop_in,
  input  wire logic          tbr_in,
  input  wire logic          txe_in,
  input  wire logic          rx_reset_in,
  input  wire logic [3:0]    err_in,
  input  wire logic [3:0]    modem_in,
  output ufc_pkg::ufc_core_t core_out
);
  logic [4:0] level_q;

  // ----------------------------------------------------------------
  // receive fifo level
  // ----------------------------------------------------------------
  // saturates at sixteen like a real fifo; a push into a full fifo is lost
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      level_q <= 5'h00;
    end else if (rx_reset_in) begin
      level_q <= 5'h00;
    end else if (push_in && level_q != 5'h10) begin
      level_q <= level_q + 5'h01;
    end else if (pop_in && level_q != 5'h00) begin
      level_q <= level_q - 5'h01;
    end
  end

  // pulses pass straight through so the block sees them in the cycle they happen
  assign core_out = '{rx_level: level_q, rx_push: push_in, rbr_read: pop_in, tbr_write: tbr_in,
                      tx_empty: txe_in, line_err: err_in, modem: modem_in};
endmodule

// ### dv/testbench.sv
// self-checking testbench of the uart fifo/irq/baud block
`timescale 1ns/100ps
`include "ufc_regs.svh"
module testbench;
  logic               clock_in;
  logic               rst_in;
  logic               psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd_v;
  logic               irq, baud16, fifo_mode, dma_mode, tx_rst, rx_rst;
  logic               push, pop, txe, transmit_buffer;
  logic [3:0]         err, modem;
  ufc_pkg::ufc_core_t core;
  int                 error_cnt, n_compared, ticks;
  int                 thr_t[4] = '{1, 4, 8, 14};
  logic [31:0]        cfg_t[4] = '{32'h0000_0000, 32'h0000_0002, 32'h0000_0004, 32'h0000_0001};
  int                 exp_t[4] = '{24, 192, 312, 312};

  ufc_top DUT (.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
    .pslverr_out(pslverr), .prdata_out(prdata), .core_in(core), .irq_out(irq), .baud16_out(baud16),
    .fifo_mode_out(fifo_mode), .dma_mode_out(dma_mode), .tx_fifo_reset_out(tx_rst),
    .rx_fifo_reset_out(rx_rst));
  ufc_core_model peer (.clock_in(clock_in), .rst_in(rst_in), .push_in(push), .pop_in(pop),
    .tbr_in(transmit_buffer), .txe_in(txe), .rx_reset_in(rx_rst), .err_in(err), .modem_in(modem), .core_out(core));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  // one apb transfer; the request is held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clock_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) error_cnt++;
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd_v);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, rd_v);
    chk(rd_v, exp);
  endtask
  task automatic push_n(input int n);
    if (n > 0) begin
      @(posedge clock_in);
      push <= 1'b1;
      repeat (n) @(posedge clock_in);
      push <= 1'b0;
      step(3);
    end
  endtask
  task automatic wait_ticks(input int n);
    int b;
    b = ticks;
    while (ticks - b < n) step(1);
  endtask
  task automatic report_and_stop;
    $display("checks run %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, tick counter, watchdog
  // ----------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  always @(posedge clock_in) if (baud16 === 1'b1) ticks++;
  // the whole sequence needs about 10000 cycles
  initial begin
    repeat (30000) @(posedge clock_in);
    error_cnt++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, push, pop, txe, transmit_buffer, err, modem} = '0;
    rst_in = 1'b1;
    repeat (8) @(posedge clock_in);
    rst_in <= 1'b0;
    #1;
    rc(`UFC_OFF_INT_ID, 32'h0000_0001);
    rc(`UFC_OFF_INT_ENABLE, 32'h0000_0000);
    apb(1'b0, 8'h24, 32'h0000_0000, rd_v);
    chk({perr, rd_v[30:0]}, 32'h8000_0000);
    wr(`UFC_OFF_INT_ENABLE, 32'h0000_00FF);
    rc(`UFC_OFF_INT_ENABLE, 32'h0000_000F);
    wr(`UFC_OFF_FIFO_CONTROL, 32'h0000_0008);
    chk({fifo_mode, dma_mode}, 32'h0);
    wr(`UFC_OFF_FIFO_CONTROL, 32'h0000_000F);
    chk({tx_rst, rx_rst, fifo_mode, dma_mode}, 32'hF);
    step(1);
    chk({tx_rst, rx_rst}, 32'h0);
    rc(`UFC_OFF_INT_ID, 32'h0000_00C1);
    // each threshold: one byte short stays quiet, the next byte raises data ready
    for (int i = 0; i < 4; i++) begin
      wr(`UFC_OFF_FIFO_CONTROL, {24'h0, i[1:0], 6'h03});
      step(2);
      push_n(thr_t[i] - 1);
      rc(`UFC_OFF_INT_ID, 32'h0000_00C1);
      push_n(1);
      rc(`UFC_OFF_INT_ID, 32'h0000_00C4);
    end
    chk(irq, 32'h0);
    wr(`UFC_OFF_HS_CONTROL, 32'h0000_0008);
    step(2);
    chk(irq, 32'h1);
    @(posedge clock_in);
    err <= 4'h1;
    @(posedge clock_in);
    err <= 4'h0;
    step(3);
    rc(`UFC_OFF_INT_ID, 32'h0000_00C6);
    apb(1'b0, `UFC_OFF_LINE_STATUS, 32'h0000_0000, rd_v);
    chk(rd_v[4:1], 32'h1);
    rc(`UFC_OFF_INT_ID, 32'h0000_00C4);
    @(posedge clock_in);
    pop <= 1'b1;
    @(posedge clock_in);
    pop <= 1'b0;
    step(3);
    rc(`UFC_OFF_INT_ID, 32'h0000_00C1);
    chk(irq, 32'h0);
    wr(`UFC_OFF_FIFO_CONTROL, 32'h0000_0000);
    rc(`UFC_OFF_INT_ID, 32'h0000_0004);
    wr(`UFC_OFF_INT_ENABLE, 32'h0000_0002);
    @(posedge clock_in);
    txe <= 1'b1;
    step(4);
    rc(`UFC_OFF_INT_ID, 32'h0000_0002);
    rc(`UFC_OFF_INT_ID, 32'h0000_0001);
    // a second empty edge, then a buffer write clears it without any read
    @(posedge clock_in);
    txe <= 1'b0;
    @(posedge clock_in);
    txe <= 1'b1;
    step(3);
    chk(irq, 32'h1);
    @(posedge clock_in);
    transmit_buffer <= 1'b1;
    @(posedge clock_in);
    transmit_buffer <= 1'b0;
    step(3);
    chk(irq, 32'h0);
    wr(`UFC_OFF_INT_ENABLE, 32'h0000_0008);
    @(posedge clock_in);
    modem <= 4'h1;
    step(4);
    rc(`UFC_OFF_INT_ID, 32'h0000_0000);
    rc(`UFC_OFF_HS_STATUS, 32'h0000_0011);
    rc(`UFC_OFF_INT_ID, 32'h0000_0001);
    // 1300 clocks carry 312 reference ticks; allow two ticks of phase slack
    wr(`UFC_OFF_DIVISOR_HIGH, 32'h0000_0000);
    wr(`UFC_OFF_DIVISOR_LOW, 32'h0000_0001);
    for (int k = 0; k < 5; k++) begin
      wr(`UFC_OFF_CONFIG, (k < 4) ? cfg_t[k] : 32'h0000_0004);
      if (k == 4) wr(`UFC_OFF_DIVISOR_LOW, 32'h0000_0002);
      step(20);
      begin
        int b;
        int e;
        b = ticks;
        e = (k < 4) ? exp_t[k] : 156;
        step(1300);
        chk(((ticks - b) >= e - 2) && ((ticks - b) <= e + 2), 32'h1);
      end
    end
    wr(`UFC_OFF_DIVISOR_LOW, 32'h0000_0001);
    wr(`UFC_OFF_INT_ENABLE, 32'h0000_0001);
    wr(`UFC_OFF_FIFO_CONTROL, 32'h0000_00C3);
    step(2);
    push_n(1);
    wait_ticks(610);
    rc(`UFC_OFF_INT_ID, 32'h0000_00C1);
    wait_ticks(50);
    rc(`UFC_OFF_INT_ID, 32'h0000_00CC);
    @(posedge clock_in);
    pop <= 1'b1;
    @(posedge clock_in);
    pop <= 1'b0;
    step(3);
    rc(`UFC_OFF_INT_ID, 32'h0000_00C1);
    // a large divisor would hold the generator for a long period, so it is read back last
    wr(`UFC_OFF_DIVISOR_HIGH, 32'h0000_00A5);
    rc(`UFC_OFF_DIVISOR_HIGH, 32'h0000_00A5);
    report_and_stop();
  end
endmodule
